// file: dpmbx_pkg.sv
/*
  package for the host-side controller of a two-port shared ram with mailboxes.
  assumes a clocked host that drives both ports of the ram synchronously to sys_clk.
*/
package dpmbx_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  // mailbox word offsets in the shared ram
  localparam logic [10:0] MBX_RIGHT_TO_LEFT = 11'h3fe;
  localparam logic [10:0] MBX_LEFT_TO_RIGHT = 11'h3ff;
  // most significant address bit position; not referenced, segmentation indexes bit 10 directly
  localparam int SEG_BIT = ADDR_W - 1;
  // cycles a port access stays on the pins
  localparam logic [1:0] ACC_CYCLES = 2'h2;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] wdata;
    logic wr;
  } dpmbx_req_t;

  typedef enum logic [1:0] {
    DPMBX_IDLE = 2'b00,
    DPMBX_WAIT = 2'b01,
    DPMBX_ACC = 2'b10,
    DPMBX_DONE = 2'b11
  } dpmbx_state_t;
endpackage : dpmbx_pkg

// file: dpmbx_port.sv
/*
  one port sequencer: takes a request, stalls while the device reports busy,
  holds the access for a fixed count and returns read data from a flip-flop.
  assumes the device pins are sampled synchronously to sys_clk.
*/
module dpmbx_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // user side
  input wire logic req_valid,
  input wire dpmbx_pkg::dpmbx_req_t req,
  output logic req_ready,
  output logic done,
  output logic [7:0] rdata,
  // device side
  input wire logic busy_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  output logic [10:0] addr,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  dpmbx_pkg::dpmbx_state_t state;
  dpmbx_pkg::dpmbx_state_t next_state;
  dpmbx_pkg::dpmbx_req_t hold;
  dpmbx_pkg::dpmbx_req_t next_hold;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic [7:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    next_hold = hold;
    next_cnt = cnt;
    next_rdata = rdata;
    case (state)
      dpmbx_pkg::DPMBX_IDLE:
      begin
        if (req_valid)
        begin
          next_hold = req;
          next_state = dpmbx_pkg::DPMBX_WAIT;
        end
      end
      dpmbx_pkg::DPMBX_WAIT:
      begin
        // stall while the device flags a matching address
        if (busy_n)
        begin
          next_cnt = dpmbx_pkg::ACC_CYCLES;
          next_state = dpmbx_pkg::DPMBX_ACC;
        end
      end
      dpmbx_pkg::DPMBX_ACC:
      begin
        // busy mid-access restarts the wait; data from a contended cycle is untrusted
        if (!busy_n)
          next_state = dpmbx_pkg::DPMBX_WAIT;
        else if (cnt == 2'h1)
        begin
          next_rdata = dq_in;
          next_state = dpmbx_pkg::DPMBX_DONE;
        end
        else
          next_cnt = cnt - 2'h1;
      end
      dpmbx_pkg::DPMBX_DONE: next_state = dpmbx_pkg::DPMBX_IDLE;
      default: next_state = dpmbx_pkg::DPMBX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state <= dpmbx_pkg::DPMBX_IDLE;
      hold <= '0;
      cnt <= 2'h0;
      rdata <= 8'h00;
    end
    else
    begin
      state <= next_state;
      hold <= next_hold;
      cnt <= next_cnt;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign req_ready = (state == dpmbx_pkg::DPMBX_IDLE);
  assign done = (state == dpmbx_pkg::DPMBX_DONE);
  assign addr = hold.addr;
  assign dq_out = hold.wdata;
  assign ce_n = (state != dpmbx_pkg::DPMBX_ACC);
  assign we_n = !((state == dpmbx_pkg::DPMBX_ACC) && hold.wr);
  assign oe_n = !((state == dpmbx_pkg::DPMBX_ACC) && !hold.wr);
  assign dq_oe_n = we_n;

  a_no_acc_busy: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == dpmbx_pkg::DPMBX_ACC && !busy_n) |=> (state == dpmbx_pkg::DPMBX_WAIT))
    else $error("access continued while busy");
endmodule : dpmbx_port

// file: dpmbx_host.sv
/*
  host-side controller for a two-port shared ram with contention busy and mailboxes.
  drives both ports, optionally segments the address space with a bank select,
  and sends or collects mailbox status words.
  assumes the device answers within the fixed access count and is synchronous to sys_clk.
*/
// Behaviour
// - each port stalls its access while its busy is asserted.
// - left write to left_to_right_mailbox raises the right-port interrupt.
// - right read of left_to_right_mailbox releases the right-port interrupt.
// - right write to right_to_left_mailbox raises the left-port interrupt.
// - left read of right_to_left_mailbox releases the left-port interrupt.
// - segmented mode drives left msb with select and right msb with inverse.
// - toggling the segment select after a table update swaps the halves.
module dpmbx_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // left user port
  input wire logic l_valid,
  input wire dpmbx_pkg::dpmbx_req_t l_req,
  output logic l_ready,
  output logic l_done,
  output logic [7:0] l_rdata,
  // right user port
  input wire logic r_valid,
  input wire dpmbx_pkg::dpmbx_req_t r_req,
  output logic r_ready,
  output logic r_done,
  output logic [7:0] r_rdata,
  // mailbox helpers: one-cycle pulses
  input wire logic l_send,
  input wire logic r_send,
  input wire logic [7:0] send_word,
  output logic l_msg_valid,
  output logic [7:0] l_msg,
  output logic r_msg_valid,
  output logic [7:0] r_msg,
  // segmentation
  input wire logic seg_enable,
  input wire logic seg_swap,
  output logic seg_select,
  // device left pins
  input wire logic dev_busy_l_n,
  input wire logic dev_int_l_n,
  input wire logic [7:0] dev_dq_l_in,
  output logic [7:0] dev_dq_l_out,
  output logic dev_dq_l_oe_n,
  output logic [10:0] dev_addr_l,
  output logic dev_ce_l_n,
  output logic dev_we_l_n,
  output logic dev_oe_l_n,
  // device right pins
  input wire logic dev_busy_r_n,
  input wire logic dev_int_r_n,
  input wire logic [7:0] dev_dq_r_in,
  output logic [7:0] dev_dq_r_out,
  output logic dev_dq_r_oe_n,
  output logic [10:0] dev_addr_r,
  output logic dev_ce_r_n,
  output logic dev_we_r_n,
  output logic dev_oe_r_n
);
  dpmbx_pkg::dpmbx_req_t l_pick;
  dpmbx_pkg::dpmbx_req_t r_pick;
  logic l_go;
  logic r_go;
  logic l_mbx_rd;
  logic r_mbx_rd;
  logic next_l_mbx_rd;
  logic next_r_mbx_rd;
  logic next_seg_select;
  logic [7:0] next_l_msg;
  logic [7:0] next_r_msg;
  logic [10:0] l_addr_raw;
  logic [10:0] r_addr_raw;

  ////////////////////////////////////////////////////////////////////////////
  // request muxing: mailbox traffic is built here, user traffic passes through.
  // a pending interrupt takes priority so status is collected before it is overwritten.
  function automatic dpmbx_pkg::dpmbx_req_t mbx_req(input logic [10:0] a,
                                                   input logic w, input logic [7:0] d);
    dpmbx_pkg::dpmbx_req_t r;
    r.addr = a;
    r.wr = w;
    r.wdata = d;
    return r;
  endfunction : mbx_req

  always_comb
  begin
    l_pick = l_req;
    r_pick = r_req;
    l_go = l_valid;
    r_go = r_valid;
    next_l_mbx_rd = l_mbx_rd;
    next_r_mbx_rd = r_mbx_rd;
    if (l_ready)
    begin
      next_l_mbx_rd = 1'b0;
      if (!dev_int_l_n)
      begin
        // read clears the left interrupt and returns the status word
        l_pick = mbx_req(dpmbx_pkg::MBX_RIGHT_TO_LEFT, 1'b0, 8'h00);
        l_go = 1'b1;
        next_l_mbx_rd = 1'b1;
      end
      else if (l_send)
      begin
        l_pick = mbx_req(dpmbx_pkg::MBX_LEFT_TO_RIGHT, 1'b1, send_word);
        l_go = 1'b1;
      end
    end
    if (r_ready)
    begin
      next_r_mbx_rd = 1'b0;
      if (!dev_int_r_n)
      begin
        r_pick = mbx_req(dpmbx_pkg::MBX_LEFT_TO_RIGHT, 1'b0, 8'h00);
        r_go = 1'b1;
        next_r_mbx_rd = 1'b1;
      end
      else if (r_send)
      begin
        r_pick = mbx_req(dpmbx_pkg::MBX_RIGHT_TO_LEFT, 1'b1, send_word);
        r_go = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // segment select and captured status words
  always_comb
  begin
    next_seg_select = seg_select ^ seg_swap;
    next_l_msg = (l_done && l_mbx_rd) ? l_rdata : l_msg;
    next_r_msg = (r_done && r_mbx_rd) ? r_rdata : r_msg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      seg_select <= 1'b0;
      l_mbx_rd <= 1'b0;
      r_mbx_rd <= 1'b0;
      l_msg <= 8'h00;
      r_msg <= 8'h00;
    end
    else
    begin
      seg_select <= next_seg_select;
      l_mbx_rd <= next_l_mbx_rd;
      r_mbx_rd <= next_r_mbx_rd;
      l_msg <= next_l_msg;
      r_msg <= next_r_msg;
    end
  end

  assign l_msg_valid = l_done && l_mbx_rd;
  assign r_msg_valid = r_done && r_mbx_rd;

  ////////////////////////////////////////////////////////////////////////////
  // port sequencers; each stalls on its own busy until it is released
  dpmbx_port u_left (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .req_valid(l_go),
    .req(l_pick),
    .req_ready(l_ready),
    .done(l_done),
    .rdata(l_rdata),
    .busy_n(dev_busy_l_n),
    .dq_in(dev_dq_l_in),
    .dq_out(dev_dq_l_out),
    .dq_oe_n(dev_dq_l_oe_n),
    .addr(l_addr_raw),
    .ce_n(dev_ce_l_n),
    .we_n(dev_we_l_n),
    .oe_n(dev_oe_l_n)
  );

  dpmbx_port u_right (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .req_valid(r_go),
    .req(r_pick),
    .req_ready(r_ready),
    .done(r_done),
    .rdata(r_rdata),
    .busy_n(dev_busy_r_n),
    .dq_in(dev_dq_r_in),
    .dq_out(dev_dq_r_out),
    .dq_oe_n(dev_dq_r_oe_n),
    .addr(r_addr_raw),
    .ce_n(dev_ce_r_n),
    .we_n(dev_we_r_n),
    .oe_n(dev_oe_r_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // segmentation overrides the msb on both ports so the addresses never meet;
  // mailbox locations then sit in different halves, a limitation of this mode
  assign dev_addr_l = seg_enable ? {seg_select, l_addr_raw[9:0]} : l_addr_raw;
  assign dev_addr_r = seg_enable ? {!seg_select, r_addr_raw[9:0]} : r_addr_raw;

  a_seg_msbs_differ: assert property (@(posedge sys_clk) disable iff (!reset_n)
    seg_enable |-> (dev_addr_l[10] != dev_addr_r[10]))
    else $error("segment msbs equal");
  a_seg_swap_toggle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    seg_swap |=> (seg_select != $past(seg_select)))
    else $error("segment select did not toggle");
  a_left_int_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (l_ready && !dev_int_l_n) |=> (!l_ready && l_mbx_rd))
    else $error("left interrupt not serviced");
  a_right_int_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (r_ready && !dev_int_r_n) |=> (!r_ready && r_mbx_rd))
    else $error("right interrupt not serviced");
  a_left_msg_cap: assert property (@(posedge sys_clk) disable iff (!reset_n)
    l_msg_valid |=> (l_msg == $past(l_rdata)))
    else $error("left status word lost");
  a_right_msg_cap: assert property (@(posedge sys_clk) disable iff (!reset_n)
    r_msg_valid |=> (r_msg == $past(r_rdata)))
    else $error("right status word lost");
  a_left_send_wr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (l_ready && dev_int_l_n && l_send) |-> (l_pick.wr && l_pick.addr == 11'h3ff))
    else $error("left send wrong target");
  a_right_send_wr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (r_ready && dev_int_r_n && r_send) |-> (r_pick.wr && r_pick.addr == 11'h3fe))
    else $error("right send wrong target");
endmodule : dpmbx_host

// file: dpmbx_dev_model.sv
/*
  behavioural model of the two-port shared ram with busy and mailboxes.
  assumes the host changes its pins just after rising edges of sys_clk.
*/
module dpmbx_dev_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // left pins
  input wire logic [10:0] dev_addr_l,
  input wire logic dev_ce_l_n,
  input wire logic dev_we_l_n,
  input wire logic dev_oe_l_n,
  input wire logic [7:0] dev_dq_l_out,
  input wire logic dev_dq_l_oe_n,
  output logic [7:0] dev_dq_l_in,
  output logic dev_busy_l_n,
  output logic dev_int_l_n,
  // right pins
  input wire logic [10:0] dev_addr_r,
  input wire logic dev_ce_r_n,
  input wire logic dev_we_r_n,
  input wire logic dev_oe_r_n,
  input wire logic [7:0] dev_dq_r_out,
  input wire logic dev_dq_r_oe_n,
  output logic [7:0] dev_dq_r_in,
  output logic dev_busy_r_n,
  output logic dev_int_r_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:2047];
  logic [7:0] last_l;
  logic [7:0] last_r;
  logic match;
  ////////////////////////////////////////////////////////////////////////////////
  assign match = dev_addr_l == dev_addr_r;
  // left wins a tie, so two equal starts cannot lock each other out
  assign dev_busy_l_n = !(match && !dev_ce_r_n && dev_ce_l_n);
  assign dev_busy_r_n = !(match && !dev_ce_l_n);
  // a released bus shows the inverse of its last value
  assign dev_dq_l_in = (!dev_ce_l_n && !dev_oe_l_n && dev_busy_l_n) ? mem[dev_addr_l] :
    !dev_dq_l_oe_n ? dev_dq_l_out : ~last_l;
  assign dev_dq_r_in = (!dev_ce_r_n && !dev_oe_r_n && dev_busy_r_n) ? mem[dev_addr_r] :
    !dev_dq_r_oe_n ? dev_dq_r_out : ~last_r;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    last_l <= dev_dq_l_in;
    last_r <= dev_dq_r_in;
    if (!dev_ce_l_n && !dev_we_l_n && dev_busy_l_n)
    begin
      mem[dev_addr_l] <= dev_dq_l_out;
      if (dev_addr_l == dpmbx_pkg::MBX_LEFT_TO_RIGHT) dev_int_r_n <= 1'b0;
    end
    if (!dev_ce_r_n && !dev_we_r_n && dev_busy_r_n)
    begin
      mem[dev_addr_r] <= dev_dq_r_out;
      if (dev_addr_r == dpmbx_pkg::MBX_RIGHT_TO_LEFT) dev_int_l_n <= 1'b0;
    end
    if (!dev_ce_r_n && !dev_oe_r_n && dev_busy_r_n && dev_addr_r == dpmbx_pkg::MBX_LEFT_TO_RIGHT)
      dev_int_r_n <= 1'b1;
    if (!dev_ce_l_n && !dev_oe_l_n && dev_busy_l_n && dev_addr_l == dpmbx_pkg::MBX_RIGHT_TO_LEFT)
      dev_int_l_n <= 1'b1;
    // bench reset only; the last assignment of the edge wins
    if (!reset_n)
    begin
      dev_int_l_n <= 1'b1;
      dev_int_r_n <= 1'b1;
      last_l <= 8'h00;
      last_r <= 8'h00;
    end
  end
endmodule : dpmbx_dev_model

// file: tb_dpmbx_host.sv
/*
  self-checking bench for the host controller against the shared ram model.
  assumes the model answers every access within the design's fixed count.
*/
module tb_dpmbx_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, l_valid, r_valid, l_send, r_send, seg_enable, seg_swap;
  dpmbx_pkg::dpmbx_req_t l_req, r_req;
  logic [7:0] send_word, l_rdata, r_rdata, l_msg, r_msg;
  logic l_ready, r_ready, l_done, r_done, l_msg_valid, r_msg_valid, seg_select;
  logic dev_busy_l_n, dev_int_l_n, dev_dq_l_oe_n, dev_ce_l_n, dev_we_l_n, dev_oe_l_n;
  logic dev_busy_r_n, dev_int_r_n, dev_dq_r_oe_n, dev_ce_r_n, dev_we_r_n, dev_oe_r_n;
  logic [7:0] dev_dq_l_in, dev_dq_l_out, dev_dq_r_in, dev_dq_r_out, d, d2;
  logic [10:0] dev_addr_l, dev_addr_r, a;
  logic [8:0] lq[$], rq[$], e;
  logic [7:0] lmq[$], rmq[$];
  logic saw_busy, lm_d, rm_d;
  int n_errors, comparisons, cycles;

  dpmbx_host uut (.*);
  dpmbx_dev_model dev (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] g, input logic [7:0] x);
    comparisons++;
    if (g !== x)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp

  task automatic results();
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // request held until an edge sees ready, then released
  task automatic xfer(input bit s, input logic w, input logic [10:0] ad, input logic [7:0] wd,
    input logic [7:0] x);
    if (s) begin r_req <= '{ad, wd, w}; r_valid <= 1'b1; rq.push_back({!w, x}); end
    else begin l_req <= '{ad, wd, w}; l_valid <= 1'b1; lq.push_back({!w, x}); end
    do @(posedge sys_clk); while ((s ? r_ready : l_ready) !== 1'b1);
    if (s) r_valid <= 1'b0;
    else l_valid <= 1'b0;
    do @(posedge sys_clk); while ((s ? r_done : l_done) !== 1'b1);
  endtask : xfer

  task automatic send(input bit s, input logic [7:0] w);
    send_word <= w;
    if (s) begin r_send <= 1'b1; lmq.push_back(w); end
    else begin l_send <= 1'b1; rmq.push_back(w); end
    do @(posedge sys_clk); while ((s ? r_ready : l_ready) !== 1'b1);
    l_send <= 1'b0;
    r_send <= 1'b0;
    while (lmq.size() + rmq.size() > 0) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    cmp({7'h00, s ? dev_int_l_n : dev_int_r_n}, 8'h01);
  endtask : send
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end

  always @(posedge sys_clk)
  begin
    if (dev_busy_l_n === 1'b0 || dev_busy_r_n === 1'b0) saw_busy <= 1'b1;
    if (l_done === 1'b1 && l_msg_valid !== 1'b1 && lq.size() > 0)
    begin
      e = lq.pop_front();
      if (e[8]) cmp(l_rdata, e[7:0]);
    end
    if (r_done === 1'b1 && r_msg_valid !== 1'b1 && rq.size() > 0)
    begin
      e = rq.pop_front();
      if (e[8]) cmp(r_rdata, e[7:0]);
    end
    // message word lands one cycle after its pulse
    lm_d <= l_msg_valid === 1'b1;
    rm_d <= r_msg_valid === 1'b1;
    if (lm_d && lmq.size() > 0) cmp(l_msg, lmq.pop_front());
    if (rm_d && rmq.size() > 0) cmp(r_msg, rmq.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    {l_valid, r_valid, l_send, r_send, seg_enable, seg_swap, saw_busy} = 7'h00;
    l_req = '0;
    r_req = '0;
    send_word = 8'h00;
    void'($urandom(1806));
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++)
    begin
      a = 11'($urandom_range(1021));
      d = 8'($urandom);
      xfer(i[0], 1'b1, a, d, 8'h00);
      xfer(!i[0], 1'b0, a, 8'h00, d);
    end
    a = 11'h2aa;
    d = 8'($urandom);
    xfer(1'b0, 1'b1, a, d, 8'h00);
    fork
      xfer(1'b0, 1'b0, a, 8'h00, d);
      xfer(1'b1, 1'b0, a, 8'h00, d);
    join
    cmp({7'h00, saw_busy}, 8'h01);
    send(1'b0, 8'($urandom));
    send(1'b1, 8'($urandom));
    d = 8'($urandom);
    d2 = ~d;
    seg_enable <= 1'b1;
    xfer(1'b0, 1'b1, 11'h005, d, 8'h00);
    xfer(1'b1, 1'b1, 11'h005, d2, 8'h00);
    seg_swap <= 1'b1;
    @(posedge sys_clk);
    seg_swap <= 1'b0;
    @(posedge sys_clk);
    cmp({7'h00, seg_select}, 8'h01);
    xfer(1'b0, 1'b0, 11'h005, 8'h00, d2);
    xfer(1'b1, 1'b0, 11'h005, 8'h00, d);
    repeat (3) @(posedge sys_clk);
    results();
  end
endmodule : tb_dpmbx_host
